//--- rtl/flash_erase_ctrl.sv
// Purpose: Command sequencer for erase, write enable latch and status
//          register handling in a serial NOR flash.
// Assumes: Array is an external byte memory written through array_*.
// Notes:   Erase time is the sweep itself, one byte per clock.
`default_nettype none

module flash_erase_ctrl #(
    parameter int ADDR_W          = 19,
    parameter bit LARGE_PARTS     = 1'b1,
    parameter int SR_WRITE_CYCLES = flash_pkg::SR_WRITE_CYCLES
) (
    input  wire logic              clock_i,
    input  wire logic              rstn_i,
    input  wire logic              sck_i,
    input  wire logic              cs_n_i,
    input  wire logic [3:0]        io_i,
    input  wire logic              qpi_mode_i,
    output logic      [3:0]        io_o,
    output logic      [3:0]        io_oe_o,
    output logic                   array_we_o,
    output logic      [ADDR_W-1:0] array_addr_o,
    output logic      [7:0]        array_wdata_o,
    output logic      [7:0]        status_o
);
    if (ADDR_W < 15 || ADDR_W > 24 ||
        (LARGE_PARTS && ADDR_W < 17) ||
        SR_WRITE_CYCLES < 1 || SR_WRITE_CYCLES > 65535) begin : g_bad_cfg
        $error("flash_erase_ctrl: unsupported parameter values");
    end

    link_capture_if lk ();

    spi_link_rx u_link (
        .sck_i      (sck_i),
        .rstn_i     (rstn_i),
        .cs_n_i     (cs_n_i),
        .io_i       (io_i),
        .qpi_mode_i (qpi_mode_i),
        .io_o       (io_o),
        .io_oe_o    (io_oe_o),
        .lk         (lk.link)
    );

    flash_pkg::ctrl_state_t state_q;
    logic              cs_meta_q;
    logic              cs_sync_q;
    logic              cs_prev_q;
    logic              cmd_fire;
    logic              latch_q;
    logic              vol_arm_q;
    logic [5:0]        field_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [ADDR_W-1:0] last_q;
    logic [4:0]        unit_q;
    logic [15:0]       timer_q;
    logic              idle;
    logic [7:0]        frame_op;
    logic [ADDR_W-1:0] frame_addr;
    logic [4:0]        req_bits;
    logic              erase_ok;
    logic              wr_enable_hit;
    logic              wr_disable_hit;
    logic              status_wr_hit;
    logic              vol_hit;

    // Erase unit size for an opcode, zero when not an erase
    function automatic logic [4:0] unit_bits_of(input logic [7:0] op);
        case (op)
            flash_pkg::SECTOR_ERASE_CMD_A,
            flash_pkg::SECTOR_ERASE_CMD_B:
                return flash_pkg::SECTOR_BITS;
            flash_pkg::SMALL_BLOCK_ERASE_CMD:
                return flash_pkg::SMALL_BLOCK_BITS;
            flash_pkg::LARGE_BLOCK_ERASE_CMD:
                return LARGE_PARTS ? flash_pkg::LARGE_BLOCK_BITS
                                   : flash_pkg::SMALL_BLOCK_BITS;
            flash_pkg::FULL_ARRAY_ERASE_CMD_A,
            flash_pkg::FULL_ARRAY_ERASE_CMD_B:
                return 5'(ADDR_W);
            default:
                return 5'h00;
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] unit_mask(input logic [4:0] bits);
        logic [ADDR_W-1:0] m;
        m = '0;
        for (int i = 0; i < ADDR_W; i++) begin
            m[i] = (i < int'(bits));
        end
        return m;
    endfunction

    // The link clock is stopped once chip select is high, so the capture
    // is stable by the time the synchronised rise is seen here.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_prev_q <= 1'b1;
        end else begin
            cs_meta_q <= cs_n_i;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
        end
    end

    assign cmd_fire = cs_sync_q & ~cs_prev_q;
    assign idle     = (state_q == flash_pkg::ST_IDLE);

    // Partial bytes leave count off these lengths and fire nothing
    always_comb begin
        frame_op   = 8'h00;
        frame_addr = lk.shift[ADDR_W-1:0];
        if (lk.count == flash_pkg::ADDR_FRAME_BITS) begin
            frame_op = lk.shift[31:24];
        end else if (lk.count == flash_pkg::DATA_FRAME_BITS) begin
            frame_op = lk.shift[15:8];
        end else if (lk.count == flash_pkg::OPCODE_BITS) begin
            frame_op = lk.shift[7:0];
        end
    end

    assign req_bits = unit_bits_of(frame_op);

    always_comb begin
        erase_ok = 1'b0;
        if (req_bits != 5'h00) begin
            if (frame_op == flash_pkg::FULL_ARRAY_ERASE_CMD_A ||
                frame_op == flash_pkg::FULL_ARRAY_ERASE_CMD_B) begin
                erase_ok = (lk.count == flash_pkg::OPCODE_BITS);
            end else begin
                erase_ok = (lk.count == flash_pkg::ADDR_FRAME_BITS);
            end
        end
    end

    assign wr_enable_hit  = (lk.count == flash_pkg::OPCODE_BITS) &&
                            (frame_op == flash_pkg::WRITE_ENABLE_CMD);
    assign wr_disable_hit = (lk.count == flash_pkg::OPCODE_BITS) &&
                            (frame_op == flash_pkg::WRITE_DISABLE_CMD);
    assign vol_hit        = (lk.count == flash_pkg::OPCODE_BITS) &&
                            (frame_op == flash_pkg::VOLATILE_STATUS_CMD);
    assign status_wr_hit  = (lk.count == flash_pkg::DATA_FRAME_BITS) &&
                            (frame_op == flash_pkg::WRITE_STATUS_CMD);

    // Sequencer: busy commands other than status read are ignored
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= flash_pkg::ST_IDLE;
            ptr_q   <= '0;
            last_q  <= '0;
            unit_q  <= 5'h00;
            timer_q <= 16'h0000;
        end else begin
            case (state_q)
                flash_pkg::ST_IDLE: begin
                    if (cmd_fire && erase_ok && latch_q) begin
                        state_q <= flash_pkg::ST_ERASE;
                        unit_q  <= req_bits;
                        ptr_q   <= frame_addr & ~unit_mask(req_bits);
                        last_q  <= frame_addr | unit_mask(req_bits);
                    end else if (cmd_fire && status_wr_hit && !vol_arm_q &&
                                 latch_q) begin
                        state_q <= flash_pkg::ST_SRWRITE;
                        timer_q <= 16'(SR_WRITE_CYCLES - 1);
                    end
                end
                flash_pkg::ST_ERASE: begin
                    ptr_q <= ptr_q + 1'b1;
                    if (ptr_q == last_q) begin
                        state_q <= flash_pkg::ST_IDLE;
                    end
                end
                flash_pkg::ST_SRWRITE: begin
                    timer_q <= timer_q - 16'h0001;
                    if (timer_q == 16'h0000) begin
                        state_q <= flash_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= flash_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            latch_q <= 1'b0;
        end else if (!idle) begin
            if ((state_q == flash_pkg::ST_ERASE && ptr_q == last_q) ||
                (state_q == flash_pkg::ST_SRWRITE &&
                 timer_q == 16'h0000)) begin
                latch_q <= 1'b0;
            end
        end else if (cmd_fire) begin
            if (wr_enable_hit) begin
                latch_q <= 1'b1;
            end else if (wr_disable_hit) begin
                latch_q <= 1'b0;
            end
        end
    end

    // Arms the next status write to the volatile copy only
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vol_arm_q <= 1'b0;
        end else if (cmd_fire && idle && lk.count[2:0] == 3'h0 &&
                     lk.count != 6'h00) begin
            vol_arm_q <= vol_hit;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            field_q <= flash_pkg::FIELD_RESET;
        end else if (cmd_fire && idle && status_wr_hit &&
                     (vol_arm_q || latch_q)) begin
            field_q <= lk.shift[flash_pkg::FIELD_LSB +: flash_pkg::FIELD_W];
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            array_we_o    <= 1'b0;
            array_addr_o  <= '0;
            array_wdata_o <= 8'hff;
        end else begin
            array_we_o    <= (state_q == flash_pkg::ST_ERASE);
            array_addr_o  <= ptr_q;
            array_wdata_o <= 8'hff;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_o <= 8'h00;
        end else begin
            status_o <= {field_q, latch_q, !idle};
        end
    end

    assign lk.status = status_o;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    erase_ones_a:
        assert property (array_we_o |-> array_wdata_o == 8'hff)
        else $error("erase write is not all ones");

    sweep_step_a:
        assert property ((array_we_o && $past(array_we_o)) |->
                         array_addr_o == $past(array_addr_o) + 1'b1)
        else $error("erase sweep skipped an address");

    sector_bound_a:
        assert property ((state_q == flash_pkg::ST_ERASE &&
                          unit_q == flash_pkg::SECTOR_BITS) |->
                         (ptr_q >> 12) == (last_q >> 12))
        else $error("sector sweep left its sector");

    start_on_cs_a:
        assert property ($rose(state_q == flash_pkg::ST_ERASE) |->
                         $past(cmd_fire))
        else $error("erase started without chip select rise");

    busy_during_a:
        assert property (array_we_o |-> status_o[flash_pkg::BUSY_BIT])
        else $error("array written while busy flag low");

    latch_after_done_a:
        assert property ($fell(status_o[flash_pkg::BUSY_BIT]) |->
                         !status_o[flash_pkg::LATCH_BIT])
        else $error("latch still set after completion");

    reject_no_latch_a:
        assert property ((cmd_fire && idle && erase_ok && !latch_q) |=>
                         idle ##1 !status_o[flash_pkg::BUSY_BIT])
        else $error("erase ran without the latch");

    latch_set_a:
        assert property ((cmd_fire && idle && wr_enable_hit) |=>
                         latch_q [*2])
        else $error("write enable did not set the latch");

    latch_clear_a:
        assert property ((cmd_fire && idle && wr_disable_hit) |=>
                         !latch_q ##1 !status_o[flash_pkg::LATCH_BIT])
        else $error("write disable did not clear the latch");

    status_wr_gate_a:
        assert property ($rose(state_q == flash_pkg::ST_SRWRITE) |->
                         $past(latch_q))
        else $error("status write ran without the latch");

    unit_align_a:
        assert property ($rose(state_q == flash_pkg::ST_ERASE) |->
                         (ptr_q & unit_mask(unit_q)) == '0)
        else $error("erase start not aligned to its unit");

endmodule

`default_nettype wire

//--- rtl/flash_pkg.sv
// Purpose: Shared constants and types for the flash command sequencer.
// Assumes: Byte-wide array port, one byte written per system clock.
// Notes:   Status byte layout is fixed here and used by both clock domains.
`default_nettype none

package flash_pkg;

    // Command opcodes
    localparam logic [7:0] SECTOR_ERASE_CMD_A     = 8'hd7;
    localparam logic [7:0] SECTOR_ERASE_CMD_B     = 8'h20;
    localparam logic [7:0] SMALL_BLOCK_ERASE_CMD  = 8'h52;
    localparam logic [7:0] LARGE_BLOCK_ERASE_CMD  = 8'hd8;
    localparam logic [7:0] FULL_ARRAY_ERASE_CMD_A = 8'hc7;
    localparam logic [7:0] FULL_ARRAY_ERASE_CMD_B = 8'h60;
    localparam logic [7:0] WRITE_ENABLE_CMD       = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD      = 8'h04;
    localparam logic [7:0] READ_STATUS_CMD        = 8'h05;
    localparam logic [7:0] WRITE_STATUS_CMD       = 8'h01;
    localparam logic [7:0] VOLATILE_STATUS_CMD    = 8'h50;

    // Status byte fields
    localparam int         BUSY_BIT       = 0;
    localparam int         LATCH_BIT      = 1;
    localparam int         FIELD_LSB      = 2;
    localparam int         FIELD_W        = 6;
    localparam logic [5:0] FIELD_RESET    = 6'h00;

    // Erase unit sizes as address bit counts
    localparam logic [4:0] SECTOR_BITS      = 5'h0c;
    localparam logic [4:0] SMALL_BLOCK_BITS = 5'h0f;
    localparam logic [4:0] LARGE_BLOCK_BITS = 5'h10;

    // Frame lengths in bits, counted at the link
    localparam int         CNT_W            = 6;
    localparam logic [5:0] OPCODE_BITS      = 6'h08;
    localparam logic [5:0] DATA_FRAME_BITS  = 6'h10;
    localparam logic [5:0] ADDR_FRAME_BITS  = 6'h20;
    localparam logic [5:0] CNT_SATURATE     = 6'h3c;
    localparam logic [5:0] QPI_STEP         = 6'h04;
    localparam logic [5:0] SPI_STEP         = 6'h01;

    // Self-timed status write
    localparam int CLOCK_PERIOD_NS   = 20;
    localparam int SR_WRITE_TIME_NS  = 320;
    localparam int SR_WRITE_CYCLES   =
        (SR_WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_SRWRITE
    } ctrl_state_t;

endpackage

`default_nettype wire

//--- rtl/link_capture_if.sv
// Purpose: Carries captured frame contents and the status byte between
//          the link logic and the sequencer core.
// Assumes: shift and count are only read by the core while chip select
//          is high, when the link clock stands still.
// Notes:   status crosses into the link domain through a synchroniser.
`default_nettype none

interface link_capture_if;
    logic [31:0] shift;
    logic [5:0]  count;
    logic [7:0]  status;

    modport link (output shift, output count, input status);
    modport core (input shift, input count, output status);
endinterface

`default_nettype wire

//--- rtl/spi_link_rx.sv
// Purpose: Link-side logic on the serial clock: shifts command bits in,
//          counts them, and shifts the status byte out.
// Assumes: SPI mode 0/3; input sampled on rising, output on falling edge.
// Notes:   Frame logic is cleared by chip select high, so no edge is
//          needed outside a frame.
`default_nettype none

module spi_link_rx (
    input  wire logic       sck_i,
    input  wire logic       rstn_i,
    input  wire logic       cs_n_i,
    input  wire logic [3:0] io_i,
    input  wire logic       qpi_mode_i,
    output logic      [3:0] io_o,
    output logic      [3:0] io_oe_o,
    link_capture_if.link    lk
);
    logic        frame_rst_n;
    logic        qpi_q;
    logic [7:0]  st_meta_q;
    logic [7:0]  st_sync_q;
    logic        in_frame_q;
    logic [31:0] shift_q;
    logic [31:0] shift_d;
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    logic [7:0]  op_q;

    assign frame_rst_n = rstn_i & ~cs_n_i;
    assign lk.shift    = shift_q;
    assign lk.count    = cnt_q;

    // Status is a set of loose levels from the system clock
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_meta_q  <= 8'h00;
            st_sync_q  <= 8'h00;
        end else begin
            st_meta_q  <= lk.status;
            st_sync_q  <= st_meta_q;
        end
    end

    // Mode only changes while deselected, so it is settled at select;
    // a link clock sync would miss the first two edges of a frame
    always_ff @(negedge cs_n_i or negedge rstn_i) begin
        if (!rstn_i) begin
            qpi_q <= 1'b0;
        end else begin
            qpi_q <= qpi_mode_i;
        end
    end

    always_ff @(posedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= 1'b1;
        end
    end

    always_comb begin
        logic [31:0] base_s;
        logic [5:0]  base_c;
        base_s = in_frame_q ? shift_q : 32'h0000_0000;
        base_c = in_frame_q ? cnt_q : 6'h00;
        if (qpi_q) begin
            shift_d = {base_s[27:0], io_i};
        end else begin
            shift_d = {base_s[30:0], io_i[0]};
        end
        if (base_c >= flash_pkg::CNT_SATURATE) begin
            cnt_d = base_c;
        end else if (qpi_q) begin
            cnt_d = base_c + flash_pkg::QPI_STEP;
        end else begin
            cnt_d = base_c + flash_pkg::SPI_STEP;
        end
    end

    // Capture stays put after the frame for the core to read
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_q <= 32'h0000_0000;
            cnt_q   <= 6'h00;
            op_q    <= 8'h00;
        end else begin
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            if (cnt_d == flash_pkg::OPCODE_BITS) begin
                op_q <= shift_d[7:0];
            end else if (!in_frame_q) begin
                op_q <= 8'h00;
            end
        end
    end

    always_ff @(negedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            io_o    <= 4'h0;
            io_oe_o <= 4'h0;
        end else if (op_q == flash_pkg::READ_STATUS_CMD &&
                     cnt_q >= flash_pkg::OPCODE_BITS) begin
            if (qpi_q) begin
                io_o    <= cnt_q[2] ? st_sync_q[3:0] : st_sync_q[7:4];
                io_oe_o <= 4'hf;
            end else begin
                io_o    <= {2'h0, st_sync_q[3'h7 - cnt_q[2:0]], 1'b0};
                io_oe_o <= 4'h2;
            end
        end else begin
            io_o    <= 4'h0;
            io_oe_o <= 4'h0;
        end
    end

endmodule

`default_nettype wire

//--- testbench/flash_host.sv
// Purpose: Host controller model driving one- or four-line frames.
// Assumes: Mode 0 link, clock idles low and runs only inside frames.
// Notes:   Released data lines show the inverse of their last value.
`default_nettype none

module flash_host (
    output logic       sck_o,
    output logic       cs_n_o,
    output logic [3:0] io_o,
    input  wire  [3:0] line_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Four-line frames while set; change only between frames
    logic qpi;

    initial begin
        qpi    = 1'b0;
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        io_o   = 4'h0;
    end

    // select held low
    // Chip select stays low from the opcode through the last read bit
    task automatic frame(input logic [31:0] d, input int nb, input int rb,
                         output logic [7:0] rd);
        int step;
        step = qpi ? 4 : 1;
        rd = 8'h00;
        cs_n_o = 1'b0;
        #5;
        for (int i = nb - 1; i >= 0; i -= step) begin
            if (qpi) begin
                io_o = d[i -: 4];
            end else begin
                io_o[0] = d[i];
            end
            #6 sck_o = 1'b1;
            #6 sck_o = 1'b0;
        end
        io_o = ~io_o;
        for (int i = 0; i < rb; i += step) begin
            #6 sck_o = 1'b1;
            rd = qpi ? {rd[3:0], line_i} : {rd[6:0], line_i[1]};
            #6 sck_o = 1'b0;
        end
        #6 cs_n_o = 1'b1;
        // Gap well above the four system clocks the device needs
        #200;
    endtask
endmodule

`default_nettype wire

//--- testbench/tb.sv
// Purpose: Self-checking bench for the erase and latch sequencer.
// Assumes: Small part with a 15-bit array so every sweep stays short.
// Notes:   Four-line block and full-array erases are cut by reset to cover their start only.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock_i;
    logic        rstn_i;
    logic        qpi;
    wire         sck;
    wire         cs_n;
    wire  [3:0]  hio;
    wire  [3:0]  dio;
    wire  [3:0]  oe;
    wire  [3:0]  line;
    wire         we;
    wire  [14:0] addr;
    wire  [7:0]  wdata;
    wire  [7:0]  status_o;
    logic [14:0] first;
    logic [14:0] last;
    int          nwr;
    int          miscompares;
    int          checks;

    assign line = (oe & dio) | (~oe & hio);

    flash_host host (.sck_o(sck), .cs_n_o(cs_n), .io_o(hio), .line_i(line));

    flash_erase_ctrl #(.ADDR_W(15), .LARGE_PARTS(1'b0),
                       .SR_WRITE_CYCLES(2)) dut (
        .clock_i(clock_i), .rstn_i(rstn_i), .sck_i(sck), .cs_n_i(cs_n),
        .io_i(line), .qpi_mode_i(qpi), .io_o(dio), .io_oe_o(oe),
        .array_we_o(we), .array_addr_o(addr), .array_wdata_o(wdata),
        .status_o(status_o));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Sampled mid-cycle, where the write strobe is settled
    always @(negedge clock_i) begin
        if (we === 1'b1) begin
            if (nwr == 0) first <= addr;
            last <= addr;
            nwr <= nwr + 1;
            chk({24'h0, wdata}, 32'hff);
        end
    end

    task automatic cmd(input logic [31:0] d, input int nb);
        logic [7:0] r;
        host.frame(d, nb, 0, r);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 40000 && status_o[0] !== 1'b0; i++)
            @(negedge clock_i);
    endtask

    task automatic erase(input logic [7:0] op, input logic [23:0] a,
                         input int base, input int size, input bit cut);
        logic [7:0] r;
        nwr = 0;
        cmd(32'h06, 8);
        chk(status_o & 8'h03, 32'h02);
        if (op == 8'h60 || op == 8'hc7) cmd({24'h0, op}, 8);
        else cmd({op, a}, 32);
        host.frame(32'h05, 8, 8, r);
        chk(r & 8'h03, 32'h03);
        chk({17'h0, first}, base);
        if (cut) begin
            @(negedge clock_i) rstn_i = 1'b0;
            repeat (3) @(negedge clock_i);
            rstn_i = 1'b1;
            repeat (3) @(negedge clock_i);
            chk(status_o, 32'h00);
            return;
        end
        wait_idle();
        chk(nwr, size);
        chk({17'h0, last}, base + size - 1);
        chk(status_o & 8'h03, 32'h00);
    endtask

    task automatic give_verdict();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Full run is about 80k system clocks; margin kept under 100k
    initial begin
        #1800us;
        miscompares++;
        give_verdict();
    end

    initial begin
        rstn_i = 1'b0;
        nwr = 0;
        first = 15'h0;
        qpi = 1'b0;
        last = 15'h0;
        repeat (6) @(negedge clock_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clock_i);
        chk(status_o, 32'h00);
        cmd({8'h20, 24'h001000}, 32);
        chk({status_o, nwr[23:0]}, 32'h0);
        cmd(32'h06, 8);
        cmd(32'h04, 8);
        chk(status_o, 32'h00);
        erase(8'hd7, 24'h012345, 32'h2000, 4096, 1'b0);
        erase(8'h20, 24'h000fff, 32'h0, 4096, 1'b0);
        erase(8'h52, 24'h00abcd, 32'h0, 32768, 1'b0);
        erase(8'h60, 24'h0, 32'h0, 32768, 1'b0);
        cmd({8'h01, 8'h5c}, 16);
        chk(status_o, 32'h00);
        cmd(32'h06, 8);
        cmd({8'h01, 8'ha4}, 16);
        wait_idle();
        chk(status_o, 32'ha4);
        cmd(32'h50, 8);
        cmd({8'h01, 8'h58}, 16);
        chk(status_o, 32'h58);
        @(negedge clock_i);
        qpi = 1'b1;
        host.qpi = 1'b1;
        erase(8'hd7, 24'h003abc, 32'h3000, 4096, 1'b0);
        erase(8'hd8, 24'h004321, 32'h0, 32768, 1'b1);
        erase(8'hc7, 24'h0, 32'h0, 32768, 1'b1);
        give_verdict();
    end
endmodule

`default_nettype wire
